// >>> common/uc_defines.svh
`ifndef UC_DEFINES_SVH
`define UC_DEFINES_SVH

`define CLK_HZ 40000000
`define TB_HZ 10000000
`define INT_TB_DIV 4
`define NS_PER_TICK 100
`define MS_TO_TICKS(ms) ((ms) * (`TB_HZ / 1000))
`define MS_TO_CYCLES(ms) ((ms) * (`CLK_HZ / 1000))

`define REG_CTRL 8'h00
`define REG_DELAY 8'h04
`define REG_OFFSET 8'h08
`define REG_RESULT 8'h0c
`define REG_DISPLAY 8'h10
`define REG_STATUS 8'h14
`define REG_CMD 8'h18

`define CTRL_MODE_LSB 0
`define CTRL_RES_LSB 4
`define CTRL_COMMON 8
`define CTRL_NULL 9
`define CTRL_AVG 10
`define CTRL_DELAY 11
`define CTRL_HOLD 12
`define CTRL_FILTER 13
`define CTRL_SLOPE_A 14
`define CTRL_SLOPE_B 15
`define CTRL_DC_A 16
`define CTRL_DC_B 17
`define CTRL_X10_A 18
`define CTRL_X10_B 19
`define CTRL_MULT_LSB 20
`define CTRL_RESET 32'h0000_0060

`define CMD_INIT 0
`define CMD_RESTART 1
`define CMD_HOLD 2

`define STAT_GATE 0
`define STAT_VALID 1
`define STAT_EXTREF 2
`define STAT_NEG 3
`define STAT_HELD 4
`define STAT_EXP_LSB 8
`define STAT_AVG_LSB 16

`define DELAY_RESET_MS 1
`define PHASE_GATE_MS 100
`define GATE_MS_8D 10000
`define GATE_MS_7D 1000
`define GATE_MS_6D 100
`define GATE_MS_5D 10
`define GATE_MS_4D 1
`define AVG_COUNT 100
`define MANT_MAX 32'd99999999
`define ENG_STEP 1000
`define ENG_EXP_STEP 3
`define BCD_SHIFTS 27
`define PHASE_FULL 360
`define FLASH_HALF_MS 500

`endif

// >>> common/uc_pkg.sv
package uc_pkg;
  typedef enum logic [2:0] {
    single_input_frequency_mode = 3'h0,
    period_mode = 3'h1,
    ratio_mode = 3'h2,
    interval_mode = 3'h3,
    gated_totalize_mode = 3'h4,
    phase_mode = 3'h5,
    totalize_mode = 3'h6,
    stopwatch_mode = 3'h7
  } mode_type;

  typedef enum logic [5:0] {
    st_arm = 6'h01,
    st_gate = 6'h02,
    st_div = 6'h04,
    st_norm = 6'h08,
    st_bcd = 6'h10,
    st_show = 6'h20
  } state_type;

  typedef enum logic [1:0] {
    kind_meas = 2'h0,
    kind_avg = 2'h1,
    kind_norm = 2'h2
  } div_kind_type;
endpackage

// >>> design/measurement_control.sv
// The register offsets and the APB slave port are this design's own decisions.
`include "uc_defines.svh"

module measurement_control
  import uc_pkg::*;
#(
  parameter int unsigned FLASH_HALF = `MS_TO_CYCLES(`FLASH_HALF_MS)
) (
  input logic clk,
  input logic reset,
  input logic clk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic chan_a_in,
  input logic chan_b_in,
  input logic hold_key,
  input logic reset_key,
  input logic ext_ref_in,
  input logic external_reference_input,
  input logic multiplier_fitted,
  input logic standby_switch,
  input logic battery_fitted,
  input logic ac_supply_present,
  input logic supply_source_switch,
  input logic battery_warn,
  input logic battery_empty,
  output logic ref_out,
  output logic ext_ref_used,
  output logic common_route,
  output logic couple_dc_a,
  output logic couple_dc_b,
  output logic atten_x10_a,
  output logic atten_x10_b,
  output logic filter_en,
  output logic gate_open,
  output logic measure_power_en,
  output logic standby_charge_lamp,
  output logic power_off,
  output logic charge_full,
  output logic charge_trickle
);

  function automatic logic edge_of(input logic cur, input logic prev, input logic falling);
    return falling ? (prev & ~cur) : (cur & ~prev);
  endfunction

  function automatic logic [31:0] gate_ticks(input logic [3:0] digits);
    unique case (digits)
      4'h8: return 32'(`MS_TO_TICKS(`GATE_MS_8D));
      4'h7: return 32'(`MS_TO_TICKS(`GATE_MS_7D));
      4'h6: return 32'(`MS_TO_TICKS(`GATE_MS_6D));
      4'h5: return 32'(`MS_TO_TICKS(`GATE_MS_5D));
      default: return 32'(`MS_TO_TICKS(`GATE_MS_4D));
    endcase
  endfunction

  logic [31:0] ctrl_q, delay_q, offset_q, prdata_q;
  logic [31:0] time_q, time_nx, ev_a_q, eva_nx, ev_b_q, evb_nx, dt_q, per_q;
  logic [31:0] den_q, mag_q, bcd_q, bcd_adj, disp_q, res_q, q_sat, op_den;
  logic [63:0] num_q, op_num, quo_nx;
  logic [32:0] rem_q, rem_sh, rem_sub, diff;
  logic [38:0] sum_q;
  logic [26:0] sh_q;
  logic [5:0] cnt_q;
  logic [6:0] avg_cnt_q;
  logic [3:0] exp_q, tick_w;
  logic [1:0] tb_div_q;
  logic a_q, b_q, ext_q, b_src, a_ev, b_ev, hold_ev, restart_ev;
  logic wr, setup, ctrl_wr, init_cmd, tb_tick, armed, start_ev, close_ev;
  logic gate_q, valid_q, neg_q, a_seen_q, b_seen_q, ref_q, lamp_q, flash_q;
  logic off_q, full_q, trickle_q, power_q, on_battery;
  logic [31:0] flash_cnt_q;
  state_type state_q;
  div_kind_type kind_q;
  mode_type mode;

  assign mode = mode_type'(ctrl_q[`CTRL_MODE_LSB +: 3]);

  // register bus: zero wait states, read data captured in the setup cycle
  assign wr = psel & penable & pwrite & clk_en;
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = psel & penable & ~(paddr inside {`REG_CTRL, `REG_DELAY, `REG_OFFSET,
      `REG_RESULT, `REG_DISPLAY, `REG_STATUS, `REG_CMD});
  assign ctrl_wr = wr & (paddr == `REG_CTRL);
  assign init_cmd = wr & (paddr == `REG_CMD) & pwdata[`CMD_INIT];
  assign restart_ev = reset_key | (wr & (paddr == `REG_CMD) & pwdata[`CMD_RESTART]);
  assign hold_ev = hold_key | (wr & (paddr == `REG_CMD) & pwdata[`CMD_HOLD]);

  always_ff @(posedge clk) begin
    if (reset || (clk_en && init_cmd)) begin
      ctrl_q <= `CTRL_RESET;
      delay_q <= 32'(`MS_TO_TICKS(`DELAY_RESET_MS));
      offset_q <= 32'h0000_0000;
    end else if (wr) begin
      if (paddr == `REG_CTRL) begin
        ctrl_q <= pwdata;
      end
      if (paddr == `REG_DELAY) begin
        delay_q <= pwdata;
      end
      if (paddr == `REG_OFFSET) begin
        offset_q <= pwdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en && setup) begin
      unique case (paddr)
        `REG_CTRL: prdata_q <= ctrl_q;
        `REG_DELAY: prdata_q <= delay_q;
        `REG_OFFSET: prdata_q <= offset_q;
        `REG_RESULT: prdata_q <= res_q;
        `REG_DISPLAY: prdata_q <= disp_q;
        `REG_STATUS: begin
          prdata_q <= 32'h0000_0000;
          prdata_q[`STAT_GATE] <= gate_q;
          prdata_q[`STAT_VALID] <= valid_q;
          prdata_q[`STAT_EXTREF] <= external_reference_input;
          prdata_q[`STAT_NEG] <= neg_q;
          prdata_q[`STAT_HELD] <= (state_q == st_show) & ctrl_q[`CTRL_HOLD];
          prdata_q[`STAT_EXP_LSB +: 4] <= exp_q;
          prdata_q[`STAT_AVG_LSB +: 7] <= avg_cnt_q;
        end
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // timebase: internal 10 MHz from clk, or edges of the external reference
  assign ext_ref_used = external_reference_input;
  assign tb_tick = ext_ref_used ? (ext_ref_in & ~ext_q)
      : (tb_div_q == 2'(`INT_TB_DIV - 1));
  always_comb begin
    tick_w = 4'h1;
    if (ext_ref_used && multiplier_fitted) begin
      unique case (ctrl_q[`CTRL_MULT_LSB +: 2])
        2'h0: tick_w = 4'h1;
        2'h1: tick_w = 4'h2;
        2'h2: tick_w = 4'h5;
        2'h3: tick_w = 4'ha;
      endcase
    end
  end

  // the timebase keeps running in standby
  always_ff @(posedge clk) begin
    if (reset) begin
      tb_div_q <= 2'h0;
      ext_q <= 1'b0;
      ref_q <= 1'b0;
    end else if (clk_en) begin
      tb_div_q <= tb_div_q + 2'h1;
      ext_q <= ext_ref_in;
      ref_q <= ext_ref_used ? ext_ref_in : tb_div_q[1];
    end
  end
  assign ref_out = ref_q;

  // input channel selections
  assign common_route = ctrl_q[`CTRL_COMMON];
  assign couple_dc_a = ctrl_q[`CTRL_DC_A];
  assign couple_dc_b = ctrl_q[`CTRL_DC_B];
  assign atten_x10_a = ctrl_q[`CTRL_X10_A];
  assign atten_x10_b = ctrl_q[`CTRL_X10_B];
  assign filter_en = ctrl_q[`CTRL_FILTER];
  assign b_src = common_route ? chan_a_in : chan_b_in;
  assign a_ev = edge_of(chan_a_in, a_q, ctrl_q[`CTRL_SLOPE_A]
      & ~(mode inside {single_input_frequency_mode, period_mode}));
  assign b_ev = edge_of(b_src, b_q, ctrl_q[`CTRL_SLOPE_B]);

  always_ff @(posedge clk) begin
    if (reset) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (clk_en) begin
      a_q <= chan_a_in;
      b_q <= b_src;
    end
  end

  // gate control and result operands
  always_comb begin
    time_nx = time_q;
    if (tb_tick) begin
      time_nx = time_q + 32'(tick_w);
    end
    eva_nx = ev_a_q + 32'(a_ev);
    evb_nx = ev_b_q + 32'(b_ev);
    armed = ~ctrl_q[`CTRL_DELAY] | (time_q >= delay_q);
    start_ev = a_ev;
    close_ev = 1'b0;
    op_num = 64'(eva_nx);
    op_den = 32'h0000_0001;
    unique case (mode)
      single_input_frequency_mode: begin
        close_ev = a_ev & (time_q >= gate_ticks(ctrl_q[`CTRL_RES_LSB +: 4]));
        op_num = 64'(eva_nx) * 64'(`TB_HZ);
        op_den = time_nx;
      end
      period_mode: begin
        close_ev = a_ev & (time_q >= gate_ticks(ctrl_q[`CTRL_RES_LSB +: 4]));
        op_num = 64'(time_nx) * 64'(`NS_PER_TICK);
        op_den = eva_nx;
      end
      ratio_mode: begin
        close_ev = a_ev & (time_q >= gate_ticks(ctrl_q[`CTRL_RES_LSB +: 4]));
        op_den = evb_nx;
      end
      phase_mode: begin
        // fixed gate, so the figure's resolution depends on the period
        close_ev = a_ev & a_seen_q & b_seen_q
            & (time_q >= 32'(`MS_TO_TICKS(`PHASE_GATE_MS)));
        op_num = 64'(dt_q) * 64'(`PHASE_FULL);
        op_den = per_q;
      end
      interval_mode: begin
        close_ev = b_ev & armed;
        op_num = 64'(time_nx) * 64'(`NS_PER_TICK);
      end
      gated_totalize_mode: begin
        start_ev = b_ev;
        close_ev = b_ev & armed;
      end
      totalize_mode: begin
        start_ev = hold_ev;
        close_ev = hold_ev;
      end
      stopwatch_mode: begin
        start_ev = hold_ev;
        close_ev = hold_ev;
        op_num = 64'(time_nx) * 64'(`NS_PER_TICK);
      end
    endcase
  end

  // restoring divider step and double-dabble adjust
  assign rem_sh = {rem_q[31:0], num_q[63]};
  assign rem_sub = rem_sh - {1'b0, den_q};
  assign quo_nx = {num_q[62:0], ~rem_sub[32]};
  assign q_sat = (|quo_nx[63:32]) ? 32'hffff_ffff : quo_nx[31:0];
  assign diff = {1'b0, q_sat} - (ctrl_q[`CTRL_NULL] ? {1'b0, offset_q} : 33'h0);

  for (genvar g = 0; g < 8; g++) begin : g_dabble
    assign bcd_adj[4*g +: 4] = (bcd_q[4*g +: 4] >= 4'h5) ? bcd_q[4*g +: 4] + 4'h3
        : bcd_q[4*g +: 4];
  end

  always_ff @(posedge clk) begin
    if (reset || (clk_en && (init_cmd || ctrl_wr || restart_ev || ~power_q))) begin
      state_q <= st_arm;
      gate_q <= 1'b0;
      valid_q <= 1'b0;
      avg_cnt_q <= 7'h00;
      sum_q <= 39'h0;
      time_q <= 32'h0000_0000;
      ev_a_q <= 32'h0000_0000;
      ev_b_q <= 32'h0000_0000;
      cnt_q <= 6'h00;
      kind_q <= kind_meas;
      if (reset) begin
        res_q <= 32'h0000_0000;
        disp_q <= 32'h0000_0000;
        dt_q <= 32'h0000_0000;
        per_q <= 32'h0000_0000;
        num_q <= 64'h0;
        den_q <= 32'h0000_0000;
        rem_q <= 33'h0;
        mag_q <= 32'h0000_0000;
        bcd_q <= 32'h0000_0000;
        sh_q <= 27'h0;
        exp_q <= 4'h0;
        neg_q <= 1'b0;
        a_seen_q <= 1'b0;
        b_seen_q <= 1'b0;
      end
    end else if (clk_en) begin
      unique case (state_q)
        st_arm: begin
          if (start_ev) begin
            gate_q <= 1'b1;
            time_q <= 32'h0000_0000;
            ev_a_q <= 32'h0000_0000;
            ev_b_q <= 32'h0000_0000;
            a_seen_q <= 1'b0;
            b_seen_q <= 1'b0;
            state_q <= st_gate;
          end
        end
        st_gate: begin
          time_q <= time_nx;
          ev_a_q <= eva_nx;
          ev_b_q <= evb_nx;
          if (b_ev && !b_seen_q) begin
            dt_q <= time_q;
            b_seen_q <= 1'b1;
          end
          if (a_ev && !a_seen_q) begin
            per_q <= time_q;
            a_seen_q <= 1'b1;
          end
          if (close_ev) begin
            gate_q <= 1'b0;
            num_q <= op_num;
            den_q <= op_den;
            rem_q <= 33'h0;
            cnt_q <= 6'h00;
            kind_q <= kind_meas;
            state_q <= st_div;
          end
        end
        st_div: begin
          num_q <= quo_nx;
          rem_q <= rem_sub[32] ? rem_sh : rem_sub;
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h3f) begin
            cnt_q <= 6'h00;
            rem_q <= 33'h0;
            if (kind_q == kind_norm) begin
              // engineering step: drop three digits, raise the exponent
              mag_q <= q_sat;
              exp_q <= exp_q + 4'(`ENG_EXP_STEP);
              state_q <= st_norm;
            end else if (kind_q == kind_meas && ctrl_q[`CTRL_AVG]) begin
              sum_q <= sum_q + 39'(q_sat);
              if (avg_cnt_q == 7'(`AVG_COUNT - 1)) begin
                num_q <= 64'(sum_q + 39'(q_sat));
                den_q <= 32'(`AVG_COUNT);
                kind_q <= kind_avg;
                avg_cnt_q <= 7'h00;
                sum_q <= 39'h0;
              end else begin
                avg_cnt_q <= avg_cnt_q + 7'h01;
                state_q <= st_arm;
              end
            end else begin
              res_q <= q_sat;
              neg_q <= diff[32];
              mag_q <= diff[32] ? 32'(-diff) : diff[31:0];
              exp_q <= 4'h0;
              state_q <= st_norm;
            end
          end
        end
        st_norm: begin
          if (mag_q > `MANT_MAX) begin
            num_q <= 64'(mag_q);
            den_q <= 32'(`ENG_STEP);
            kind_q <= kind_norm;
            state_q <= st_div;
          end else begin
            bcd_q <= 32'h0000_0000;
            sh_q <= mag_q[26:0];
            cnt_q <= 6'h00;
            state_q <= st_bcd;
          end
        end
        st_bcd: begin
          {bcd_q, sh_q} <= {bcd_adj[30:0], sh_q, 1'b0};
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(`BCD_SHIFTS - 1)) begin
            disp_q <= {bcd_adj[30:0], sh_q[26]};
            valid_q <= 1'b1;
            state_q <= st_show;
          end
        end
        st_show: begin
          if (!ctrl_q[`CTRL_HOLD]) begin
            state_q <= st_arm;
          end
        end
        default: state_q <= st_arm;
      endcase
    end
  end
  assign gate_open = gate_q;

  // supply, charging and standby lamp
  assign on_battery = battery_fitted & ~ac_supply_present & ~supply_source_switch;

  always_ff @(posedge clk) begin
    if (reset) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q <= 1'b0;
      lamp_q <= 1'b0;
      off_q <= 1'b0;
      full_q <= 1'b0;
      trickle_q <= 1'b0;
      power_q <= 1'b0;
    end else if (clk_en) begin
      if (flash_cnt_q >= FLASH_HALF - 1) begin
        flash_cnt_q <= 32'h0000_0000;
        flash_q <= ~flash_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
      end
      // once switched off for a flat battery it stays off until reset
      off_q <= off_q | (on_battery & battery_empty);
      lamp_q <= (on_battery & battery_warn) ? flash_q : standby_switch;
      full_q <= battery_fitted & standby_switch
          & (ac_supply_present | supply_source_switch);
      trickle_q <= battery_fitted & ac_supply_present & ~standby_switch;
      power_q <= ~standby_switch & ~off_q & ~(on_battery & battery_empty);
    end
  end
  assign standby_charge_lamp = lamp_q;
  assign power_off = off_q;
  assign charge_full = full_q;
  assign charge_trickle = trickle_q;
  assign measure_power_en = power_q;

endmodule // measurement_control

// >>> tb/uc_checker.sv
module uc_checker (
  input logic clk,
  input logic reset,
  input logic clk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic ext_ref_in,
  input logic external_reference_input,
  input logic standby_switch,
  input logic battery_fitted,
  input logic ac_supply_present,
  input logic supply_source_switch,
  input logic ref_out,
  input logic ext_ref_used,
  input logic common_route,
  input logic couple_dc_a,
  input logic atten_x10_b,
  input logic gate_open,
  input logic measure_power_en,
  input logic standby_charge_lamp,
  input logic power_off,
  input logic charge_full,
  input logic charge_trickle
);
  timeunit 1ns;
  timeprecision 1ps;
  // registered outputs only follow their inputs after a live, unfrozen edge
  logic live_q;
  always_ff @(posedge clk) begin
    live_q <= !reset && clk_en;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_ref_flag: assert property (ext_ref_used == external_reference_input)
    else $error("reference flag differs from amplitude sense");
  chk_ref_follow: assert property (live_q && $past(external_reference_input) |->
    ref_out == $past(ext_ref_in)) else $error("reference output not from external");
  chk_trickle_ac: assert property (live_q |-> charge_trickle ==
    $past(battery_fitted && ac_supply_present && !standby_switch))
    else $error("trickle charge wrong");
  chk_full_rate: assert property (live_q |-> charge_full == $past(battery_fitted &&
    standby_switch && (ac_supply_present || supply_source_switch)))
    else $error("full rate charge wrong");
  chk_standby_power: assert property (live_q && $past(standby_switch) |-> !measure_power_en)
    else $error("measuring circuits powered in standby");
  chk_standby_gate: assert property (standby_switch [*6] |-> !gate_open)
    else $error("gate open in standby");
  chk_lamp_standby: assert property (live_q && $past(standby_switch) |-> standby_charge_lamp)
    else $error("standby lamp dark");
  chk_off_sticky: assert property (power_off |=> power_off)
    else $error("power off released");
  chk_off_halts: assert property (power_off [*2] |-> !measure_power_en)
    else $error("measuring while switched off");
  chk_ctrl_route: assert property (psel && penable && pwrite && paddr == 8'h00 && clk_en |=>
    common_route == $past(pwdata[8]) && couple_dc_a == $past(pwdata[16]) &&
    atten_x10_b == $past(pwdata[19])) else $error("input routing not from control");
endmodule // uc_checker

bind measurement_control uc_checker uc_checker_inst (.clk, .reset, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .ext_ref_in, .external_reference_input, .standby_switch,
  .battery_fitted, .ac_supply_present, .supply_source_switch, .ref_out, .ext_ref_used,
  .common_route, .couple_dc_a, .atten_x10_b, .gate_open, .measure_power_en,
  .standby_charge_lamp, .power_off, .charge_full, .charge_trickle);

// >>> tb/uc_signal_source.sv
module uc_signal_source (
  input wire logic clk,
  input wire logic ref_on,
  input wire logic [3:0] ref_half,
  output logic chan_a,
  output logic chan_b,
  output logic ext_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] a_cnt = '0;
  logic [3:0] r_cnt = '0;
  initial begin
    chan_a = 1'b0;
    chan_b = 1'b0;
    ext_ref = 1'b0;
  end
  // channel a period 40 clocks, b lags a quarter period
  always @(posedge clk) begin
    a_cnt <= (a_cnt == 5'd19) ? 5'd0 : a_cnt + 5'd1;
    if (a_cnt == 5'd19) chan_a <= !chan_a;
    if (a_cnt == 5'd9) chan_b <= chan_a;
    r_cnt <= (r_cnt + 4'd1 >= ref_half) ? 4'd0 : r_cnt + 4'd1;
    // absent reference: line wanders every cycle, never holds a level
    if (!ref_on || r_cnt + 4'd1 >= ref_half) ext_ref <= !ext_ref;
  end
endmodule // uc_signal_source

// >>> tb/universal_counter_measurement_control_tb_top.sv
`include "uc_defines.svh"
`define CHK(g, w) begin total_checks++; if ((g) !== (w)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, w); end end

module universal_counter_measurement_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, hold_key = 0, reset_key = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, want;
  logic [3:0] ref_half = 4'd2;
  logic ref_on = 0, multiplier_fitted = 0, standby_switch = 0, battery_fitted = 0, clk_en = 1;
  logic ac_supply_present = 1, supply_source_switch = 0, battery_warn = 0, battery_empty = 0;
  logic pready, pslverr, chan_a_in, chan_b_in, ext_ref_in, ref_out, ext_ref_used;
  logic common_route, couple_dc_a, couple_dc_b, atten_x10_a, atten_x10_b, filter_en;
  logic gate_open, measure_power_en, standby_charge_lamp, power_off, charge_full;
  logic charge_trickle;
  int bad_count = 0, total_checks = 0, cycles = 0;
  logic [31:0] exp_q[$];

  measurement_control #(.FLASH_HALF(8)) measurement_control_inst (.clk, .reset,
    .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chan_a_in, .chan_b_in, .hold_key, .reset_key, .ext_ref_in,
    .external_reference_input(ref_on), .multiplier_fitted, .standby_switch,
    .battery_fitted, .ac_supply_present, .supply_source_switch, .battery_warn,
    .battery_empty, .ref_out, .ext_ref_used, .common_route, .couple_dc_a, .couple_dc_b,
    .atten_x10_a, .atten_x10_b, .filter_en, .gate_open, .measure_power_en,
    .standby_charge_lamp, .power_off, .charge_full, .charge_trickle);
  uc_signal_source uc_signal_source_inst (.clk, .ref_on, .ref_half, .chan_a(chan_a_in),
    .chan_b(chan_b_in), .ext_ref(ext_ref_in));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 100000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // read data is taken at the access edge, oldest note first
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0) begin
      want = exp_q.pop_front();
      `CHK(prdata, want)
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    `CHK(pslverr, err)
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, '0, 1'b0);
  endtask

  task automatic key(input logic h);
    hold_key <= h;
    reset_key <= !h;
    @(posedge clk);
    hold_key <= 0;
    reset_key <= 0;
    @(posedge clk);
  endtask

  // two hold presses n clocks apart, kept clear of channel a edges
  task automatic span(input int n);
    @(posedge chan_a_in);
    repeat (10) @(posedge clk);
    key(1'b1);
    repeat (n - 2) @(posedge clk);
    key(1'b1);
    repeat (70) @(posedge clk);
  endtask

  task automatic wait_gate(input logic v, input int lim);
    int n;
    n = 0;
    while (gate_open !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    `CHK(gate_open, v)
  endtask

  task automatic check_defaults();
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_DELAY, 32'd10000);
    rd(`REG_OFFSET, 32'h0);
    `CHK({common_route, filter_en, couple_dc_a, couple_dc_b}, 4'h0)
  endtask

  initial begin
    logic [31:0] v;
    int n;
    logic s0;
    logic [7:0] s;
    void'($urandom(32'hb662d54b));
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    check_defaults();
    for (int i = 0; i < 4; i++) begin
      v = ($urandom() & 32'h000fe100) | `CTRL_RESET;
      wr(`REG_CTRL, v);
      `CHK(common_route, v[8])
      `CHK({atten_x10_b, atten_x10_a, couple_dc_b, couple_dc_a}, v[19:16])
      rd(`REG_CTRL, v);
    end
    wr(`REG_OFFSET, 32'h55);
    wr(`REG_DELAY, 32'h5);
    wr(`REG_CMD, 32'h1);
    check_defaults();
    // frozen clock enable: the write must not land
    clk_en <= 0;
    wr(`REG_OFFSET, 32'h77);
    clk_en <= 1;
    rd(`REG_OFFSET, 32'h0);
    exp_q.push_back(32'h0);
    apb(1'b0, 8'h1c, '0, 1'b1);
    apb(1'b1, 8'h1c, 32'hffffffff, 1'b1);
    $display("test setup done");
    for (int i = 0; i < 8; i++) begin
      s[i] = ref_out;
      @(posedge clk);
    end
    `CHK(s[3:0], s[7:4])
    `CHK(s[1:0] ^ s[3:2], 2'b11)
    $display("test reference done");
    wr(`REG_CTRL, 32'h00001066);
    span(400);
    rd(`REG_RESULT, 32'd10);
    span(800);
    rd(`REG_RESULT, 32'd10);
    key(1'b0);
    span(800);
    rd(`REG_RESULT, 32'd20);
    wr(`REG_DELAY, 32'd25);
    // stop edges before 25 ticks are ignored, so three channel a edges fit
    wr(`REG_CTRL, 32'h00001804);
    wait_gate(1'b1, 60);
    wait_gate(1'b0, 160);
    repeat (70) @(posedge clk);
    rd(`REG_RESULT, 32'd3);
    // common input: a rise starts, its fall seen on b stops, 20 clocks = 500 ns
    wr(`REG_CTRL, 32'h00009103);
    wait_gate(1'b1, 60);
    wait_gate(1'b0, 40);
    repeat (70) @(posedge clk);
    rd(`REG_RESULT, 32'd500);
    wr(`REG_CMD, 32'h2);
    wait_gate(1'b1, 60);
    $display("test totalize done");
    wr(`REG_OFFSET, 32'd300);
    wr(`REG_CTRL, 32'h00000667);
    repeat (100) span(40);
    // second divide by the count plus conversion outlast the span's tail
    repeat (100) @(posedge clk);
    rd(`REG_RESULT, 32'd1000);
    rd(`REG_DISPLAY, 32'h00000700);
    $display("test stopwatch done");
    ref_half <= 4'd4;
    ref_on <= 1;
    multiplier_fitted <= 1;
    wr(`REG_CTRL, 32'h00104040);
    repeat (3) @(posedge clk);
    wait_gate(1'b1, 200);
    wait_gate(1'b0, 45000);
    repeat (120) @(posedge clk);
    rd(`REG_RESULT, 32'd1000000);
    rd(`REG_DISPLAY, 32'h01000000);
    `CHK(ext_ref_used, 1'b1)
    $display("test frequency done");
    ref_on <= 0;
    for (int i = 0; i < 16; i++) begin
      {battery_fitted, ac_supply_present, standby_switch, supply_source_switch} <= i[3:0];
      repeat (3) @(posedge clk);
      `CHK(charge_full, i[3] & i[1] & (i[2] | i[0]))
      `CHK(charge_trickle, i[3] & i[2] & !i[1])
      `CHK(measure_power_en, !i[1])
    end
    {battery_fitted, ac_supply_present, standby_switch, supply_source_switch} <= 4'b1000;
    battery_warn <= 1;
    n = 0;
    repeat (40) begin
      s0 = standby_charge_lamp;
      @(posedge clk);
      if (standby_charge_lamp !== s0) n++;
    end
    `CHK(n > 2, 1'b1)
    battery_empty <= 1;
    repeat (3) @(posedge clk);
    battery_empty <= 0;
    repeat (3) @(posedge clk);
    `CHK({power_off, measure_power_en}, 2'b10)
    $display("test supply done");
    report_and_stop();
  end
endmodule // universal_counter_measurement_control_tb_top
